// *** logic/ddrbw_consts.svh ***
/*
  Constants of the write-mask block: widths, depths, burst offsets.
  Assumes inclusion by the package and by ddrbw_top; the FIFO and the array do not include it.
*/
`ifndef DDRBW_CONSTS_SVH
`define DDRBW_CONSTS_SVH
`define DDRBW_DATA_MAX 36
`define DDRBW_LANE_MAX 4
`define DDRBW_ADDR_MAX 21
`define DDRBW_DATA_W_DEF 18
`define DDRBW_ADDR_W_DEF 20
`define DDRBW_FIFO_DEPTH 16
`define DDRBW_NIBBLE_W 4
`define DDRBW_BYTE_W 9
`define DDRBW_OFS_FIRST 0
`define DDRBW_OFS_SECOND 1
`endif

// *** logic/ddrbw_pkg.sv ***
/*
  Types of the write-mask block: pin bundle, burst record, commit states.
  Assumes ddrbw_consts.svh is on the include path.
*/
package ddrbw_pkg;
`include "ddrbw_consts.svh"

  typedef struct packed {
    logic kPos;
    logic kNeg;
    logic loadCmdN;
    logic readNotWrite;
    logic [`DDRBW_LANE_MAX-1:0] selN;
    logic [`DDRBW_DATA_MAX-1:0] data;
    logic [`DDRBW_ADDR_MAX-1:0] addr;
  } ddrbw_pins_t;

  typedef struct packed {
    logic [`DDRBW_ADDR_MAX-1:0] addr;
    logic [`DDRBW_LANE_MAX-1:0] sel0N;
    logic [`DDRBW_DATA_MAX-1:0] data0;
    logic [`DDRBW_LANE_MAX-1:0] sel1N;
    logic [`DDRBW_DATA_MAX-1:0] data1;
  } ddrbw_burst_t;

  typedef enum logic [3:0] {
    CM_IDLE, CM_RD0, CM_WR0, CM_LD1, CM_RD1, CM_WR1, CM_PEEK, CM_PEEKW
  } ddrbw_commit_t;

  typedef struct packed {
    ddrbw_pins_t s1;
    ddrbw_pins_t s2;
    ddrbw_pins_t s3;
    logic pendValid;
    logic [`DDRBW_ADDR_MAX-1:0] pendAddr;
    logic word0Valid;
    ddrbw_burst_t cap;
    logic pushValid;
    ddrbw_burst_t pushData;
    ddrbw_commit_t cm;
    ddrbw_burst_t work;
    logic memWe;
    logic memRe;
    logic [`DDRBW_ADDR_MAX-1:0] memAddr;
    logic [`DDRBW_DATA_MAX-1:0] memWd;
    logic [`DDRBW_DATA_MAX-1:0] peekData;
    logic peekValid;
    logic dropped;
  } ddrbw_top_state_t;
endpackage

// *** logic/ddrbw_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides, width and depth
  as parameters. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module ddrbw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slots;
    logic [PW:0] wr;
    logic [PW:0] rd;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic full;
  logic empty;

  assign empty = (st_r.wr == st_r.rd);
  assign full = (st_r.wr[PW] != st_r.rd[PW]) &&
                (st_r.wr[PW-1:0] == st_r.rd[PW-1:0]);
  assign inReady = ~full;
  assign outValid = ~empty;
  assign outData = st_r.slots[st_r.rd[PW-1:0]];

  always_comb begin
    st_nxt = st_r;
    if (inValid && !full) begin
      st_nxt.slots[st_r.wr[PW-1:0]] = inData;
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (outReady && !empty) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// *** logic/ddrbw_mem.sv ***
/*
  Single-port storage array with registered read data.
  Assumes at most one of write or read per cycle; contents not reset.
*/
`timescale 1ns/1ps
module ddrbw_mem #(
  parameter int AW = 20,
  parameter int DW = 18
) (
  // clock
  input wire logic core_clk,
  // access port
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wrData,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] cells [2**AW];
  logic [DW-1:0] rdData_r;

  assign rdData = rdData_r;

  always_ff @(posedge core_clk) begin
    if (we) begin
      cells[addr] <= wrData;
    end
    if (re) begin
      rdData_r <= cells[addr];
    end
  end
endmodule

// *** logic/ddrbw_top.sv ***
/*
  Write port of a double-data-rate separate-io SRAM with lane write
  masks: samples the input clock pair, captures two-word bursts with
  per-word lane selects, buffers them and merges them into the array.
  Assumes the pins are asynchronous to core_clk and change slowly
  enough that each input clock level lasts at least three core cycles.
*/
`timescale 1ns/1ps
`include "ddrbw_consts.svh"
// What this block does
// - x8: nibble select 0 alone writes bits 3:0, keeps 7:4.
// - x8: nibble select 1 alone writes bits 7:4, keeps 3:0.
// - x18: byte select 0 alone writes bits 8:0, keeps 17:9.
// - x18: byte select 1 alone writes bits 17:9, keeps 8:0.
// - x8/x18: both selects low write the whole word.
// - x9: one select covers bits 8:0; high suppresses the word.
// - x36: all four selects low write all 36 bits.
// - x36: selects 0..3 cover 8:0, 17:9, 26:18, 35:27.
// - all selects high: nothing is written for that word.
// - selects are sampled separately for each burst word.
// - write data captured on rising edges of both input clocks.
// - after reset deselected, data outputs not driven.
// - first word goes to base address, second to base plus one.
module ddrbw_top
  import ddrbw_pkg::*;
#(
  parameter int DATA_W = `DDRBW_DATA_W_DEF,
  parameter int ADDR_W = `DDRBW_ADDR_W_DEF,
  parameter int FIFO_DEPTH = `DDRBW_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // input clock pair
  input wire logic inClkPos,
  input wire logic inClkNeg,
  // command pins
  input wire logic loadCmdN,
  input wire logic readNotWrite,
  input wire logic [ADDR_W-1:0] addrIn,
  // write data pins; for x8 these selects are the nibble selects
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic [((DATA_W == `DDRBW_BYTE_W) ? 1 :
    (DATA_W == 4 * `DDRBW_BYTE_W) ? 4 : 2)-1:0] byteWriteSelectN,
  // read data pins, held undriven
  output logic [DATA_W-1:0] dataOut,
  output logic dataOutEn,
  // array inspection
  input wire logic peekReq,
  output logic peekReady,
  input wire logic [ADDR_W-1:0] peekAddr,
  output logic peekValid,
  output logic [DATA_W-1:0] peekData,
  // status
  output logic bufferReady,
  output logic commitBusy,
  output logic writeDropped
);

  // ****************************************************************
  // geometry
  // ****************************************************************
  function automatic int laneCount(input int w);
    laneCount = (w == `DDRBW_BYTE_W) ? 1 : (w == 4 * `DDRBW_BYTE_W) ? 4 : 2;
  endfunction

  localparam int LANES = laneCount(DATA_W);
  localparam int LANE_W = DATA_W / LANES;
  localparam int BW = $bits(ddrbw_burst_t);

  generate
    if (!(DATA_W == 2 * `DDRBW_NIBBLE_W || DATA_W == `DDRBW_BYTE_W ||
          DATA_W == 2 * `DDRBW_BYTE_W || DATA_W == 4 * `DDRBW_BYTE_W))
    begin : g_chk_w
      $error("data width must be 8, 9, 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > `DDRBW_ADDR_MAX) begin : g_chk_a
      $error("address width out of range");
    end
  endgenerate

  // ****************************************************************
  // helpers
  // ****************************************************************
  // expand active-low lane selects to a bit write mask
  function automatic logic [DATA_W-1:0] laneMask(
    input logic [`DDRBW_LANE_MAX-1:0] selN
  );
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W; i++) begin
      m[i] = ~selN[i / LANE_W];
    end
    return m;
  endfunction

  // unmasked lanes take the new word, the rest keep the stored bits
  function automatic logic [DATA_W-1:0] mergeWord(
    input logic [DATA_W-1:0] old,
    input logic [`DDRBW_DATA_MAX-1:0] neu,
    input logic [`DDRBW_LANE_MAX-1:0] selN
  );
    logic [DATA_W-1:0] m;
    m = laneMask(selN);
    return (neu[DATA_W-1:0] & m) | (old & ~m);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  ddrbw_top_state_t st_r;
  ddrbw_top_state_t st_nxt;
  ddrbw_pins_t pinsNow;
  logic kPosRise;
  logic kNegRise;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [BW-1:0] fifoOutData;
  ddrbw_burst_t head;
  logic [DATA_W-1:0] memRd;

  always_comb begin
    pinsNow = '0;
    pinsNow.kPos = inClkPos;
    pinsNow.kNeg = inClkNeg;
    pinsNow.loadCmdN = loadCmdN;
    pinsNow.readNotWrite = readNotWrite;
    pinsNow.selN = `DDRBW_LANE_MAX'(byteWriteSelectN);
    pinsNow.data = `DDRBW_DATA_MAX'(dataIn);
    pinsNow.addr = `DDRBW_ADDR_MAX'(addrIn);
  end

  // edges are taken between the second and third stage only
  assign kPosRise = st_r.s2.kPos & ~st_r.s3.kPos;
  assign kNegRise = st_r.s2.kNeg & ~st_r.s3.kNeg;
  assign head = ddrbw_burst_t'(fifoOutData);
  assign fifoOutReady = (st_r.cm == CM_IDLE);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinsNow;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.pushValid = 1'b0;
    st_nxt.memWe = 1'b0;
    st_nxt.memRe = 1'b0;
    st_nxt.peekValid = 1'b0;
    st_nxt.dropped = 1'b0;

    // capture side
    if (kPosRise) begin
      if (st_r.pendValid) begin
        st_nxt.cap.addr = st_r.pendAddr;
        st_nxt.cap.data0 = st_r.s2.data;
        st_nxt.cap.sel0N = st_r.s2.selN;
        st_nxt.word0Valid = 1'b1;
      end
      // a new write may be loaded while the previous data arrives
      st_nxt.pendValid = ~st_r.s2.loadCmdN & ~st_r.s2.readNotWrite;
      st_nxt.pendAddr = st_r.s2.addr;
    end
    if (kNegRise && st_r.word0Valid) begin
      st_nxt.cap.data1 = st_r.s2.data;
      st_nxt.cap.sel1N = st_r.s2.selN;
      st_nxt.word0Valid = 1'b0;
      st_nxt.pushValid = 1'b1;
      st_nxt.pushData = st_nxt.cap;
    end
    if (st_r.pushValid && !fifoInReady) begin
      st_nxt.dropped = 1'b1;
    end

    // commit side
    case (st_r.cm)
      CM_IDLE: begin
        if (fifoOutValid) begin
          st_nxt.work = head;
          st_nxt.memRe = 1'b1;
          st_nxt.memAddr = `DDRBW_ADDR_MAX'(head.addr[ADDR_W-1:0] +
                           ADDR_W'(`DDRBW_OFS_FIRST));
          st_nxt.cm = CM_RD0;
        end else if (peekReq) begin
          st_nxt.memRe = 1'b1;
          st_nxt.memAddr = `DDRBW_ADDR_MAX'(peekAddr);
          st_nxt.cm = CM_PEEK;
        end
      end
      CM_RD0: begin
        st_nxt.cm = CM_WR0;
      end
      CM_WR0: begin
        st_nxt.memWe = |laneMask(st_r.work.sel0N);
        st_nxt.memWd = `DDRBW_DATA_MAX'(
          mergeWord(memRd, st_r.work.data0, st_r.work.sel0N));
        st_nxt.cm = CM_LD1;
      end
      CM_LD1: begin
        st_nxt.memRe = 1'b1;
        st_nxt.memAddr = `DDRBW_ADDR_MAX'(st_r.work.addr[ADDR_W-1:0] +
                         ADDR_W'(`DDRBW_OFS_SECOND));
        st_nxt.cm = CM_RD1;
      end
      CM_RD1: begin
        st_nxt.cm = CM_WR1;
      end
      CM_WR1: begin
        st_nxt.memWe = |laneMask(st_r.work.sel1N);
        st_nxt.memWd = `DDRBW_DATA_MAX'(
          mergeWord(memRd, st_r.work.data1, st_r.work.sel1N));
        st_nxt.cm = CM_IDLE;
      end
      CM_PEEK: begin
        st_nxt.cm = CM_PEEKW;
      end
      CM_PEEKW: begin
        st_nxt.peekData = `DDRBW_DATA_MAX'(memRd);
        st_nxt.peekValid = 1'b1;
        st_nxt.cm = CM_IDLE;
      end
      default: begin
        st_nxt.cm = CM_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // buffer and array
  // ****************************************************************
  ddrbw_fifo #(
    .WIDTH(BW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inValid(st_r.pushValid),
    .inReady(fifoInReady),
    .inData(st_r.pushData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  ddrbw_mem #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_mem (
    .core_clk(core_clk),
    .we(st_r.memWe),
    .re(st_r.memRe),
    .addr(st_r.memAddr[ADDR_W-1:0]),
    .wrData(st_r.memWd[DATA_W-1:0]),
    .rdData(memRd)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // read path is outside this block: outputs stay deselected
  assign dataOut = '0;
  assign dataOutEn = 1'b0;
  assign peekReady = (st_r.cm == CM_IDLE) & ~fifoOutValid;
  assign peekValid = st_r.peekValid;
  assign peekData = st_r.peekData[DATA_W-1:0];
  assign bufferReady = fifoInReady;
  assign commitBusy = (st_r.cm != CM_IDLE) | fifoOutValid;
  assign writeDropped = st_r.dropped;
endmodule

// *** test/ddrbw_ctrl_model.sv ***
/*
  Controller model driving the write-port pins of the write-mask top.
  Assumes a free core_clk; each input clock level lasts 7 core cycles, except the last inClkNeg high level of a burst, 4.
*/
`timescale 1ns/1ps
module ddrbw_ctrl_model (
  // clock
  input wire logic core_clk,
  // pins toward the device
  output logic inClkPos,
  output logic inClkNeg,
  output logic loadCmdN,
  output logic readNotWrite,
  output logic [19:0] addrIn,
  output logic [17:0] dataIn,
  output logic [1:0] byteWriteSelectN
);
  // ****************
  // pin sequencing
  // ****************
  initial begin
    inClkPos = 1'b0;
    inClkNeg = 1'b0;
    loadCmdN = 1'b1;
    readNotWrite = 1'b1;
    addrIn = 20'h00000;
    dataIn = 18'h00000;
    byteWriteSelectN = 2'h3;
  end

  // one clock level: settle 3 cycles, edge, hold 3 cycles
  task automatic phase(input logic k, input logic ld, input logic rnw,
      input logic [19:0] a, input logic [17:0] d, input logic [1:0] s);
    @(posedge core_clk);
    loadCmdN <= ld;
    readNotWrite <= rnw;
    addrIn <= a;
    dataIn <= d;
    byteWriteSelectN <= s;
    repeat (3) @(posedge core_clk);
    inClkPos <= k;
    inClkNeg <= ~k;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic burst(input logic rnw, input logic [19:0] a,
      input logic [17:0] d0, input logic [1:0] s0,
      input logic [17:0] d1, input logic [1:0] s1);
    phase(1'b1, 1'b0, rnw, a, ~d1, ~s1);
    phase(1'b0, 1'b1, 1'b1, ~a, ~d0, ~s0);
    phase(1'b1, 1'b1, 1'b0, ~a, d0, s0);
    phase(1'b0, 1'b1, 1'b0, a, d1, s1);
    // clocks parked equal, released pins toggled
    @(posedge core_clk);
    inClkNeg <= 1'b0;
    dataIn <= ~d1;
    byteWriteSelectN <= ~s1;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

// *** test/ddrbw_top_sva.sv ***
/*
  Checker on the ports of the write-mask top.
  Assumes one clock domain; bound to every ddrbw_top.
*/
`timescale 1ns/1ps
module ddrbw_top_sva #(
  parameter int DATA_W = 18
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // watched ports
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOutEn,
  input wire logic peekReq,
  input wire logic peekReady,
  input wire logic peekValid,
  input wire logic [DATA_W-1:0] peekData,
  input wire logic bufferReady,
  input wire logic commitBusy,
  input wire logic writeDropped
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_outIdle;
    !dataOutEn && dataOut == '0;
  endproperty
  a_outIdle: assert property (p_outIdle)
    else $error("read pins driven");

  property p_readyAfterReset;
    $fell(sys_rst) |-> bufferReady && peekReady && !commitBusy;
  endproperty
  a_readyAfterReset: assert property (p_readyAfterReset)
    else $error("not idle after reset");

  property p_peekAnswer;
    peekReq && peekReady |=> !peekValid [*2] ##1 peekValid;
  endproperty
  a_peekAnswer: assert property (p_peekAnswer)
    else $error("peek answer late or early");

  property p_peekPulse;
    peekValid |=> !peekValid;
  endproperty
  a_peekPulse: assert property (p_peekPulse)
    else $error("peek valid too long");

  property p_peekHold;
    !$stable(peekData) |-> peekValid;
  endproperty
  a_peekHold: assert property (p_peekHold)
    else $error("peek data moved");

  property p_busyNoPeek;
    commitBusy |-> !peekReady;
  endproperty
  a_busyNoPeek: assert property (p_busyNoPeek)
    else $error("peek ready while busy");

  property p_dropPulse;
    writeDropped |=> !writeDropped;
  endproperty
  a_dropPulse: assert property (p_dropPulse)
    else $error("drop flag too long");

  property p_dropFull;
    writeDropped |-> !$past(bufferReady) || !$past(bufferReady, 2);
  endproperty
  a_dropFull: assert property (p_dropFull)
    else $error("drop with room left");
endmodule

bind ddrbw_top ddrbw_top_sva #(.DATA_W(DATA_W)) u_ddrbw_top_sva (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .dataOut(dataOut),
  .dataOutEn(dataOutEn),
  .peekReq(peekReq),
  .peekReady(peekReady),
  .peekValid(peekValid),
  .peekData(peekData),
  .bufferReady(bufferReady),
  .commitBusy(commitBusy),
  .writeDropped(writeDropped)
);

// *** test/ddr_sram_byte_write_mask_test.sv ***
/*
  Bench: masked two-word bursts, then array peeks of both words.
  Assumes the controller model drives the pins, checker bound.
*/
`timescale 1ns/1ps
module ddr_sram_byte_write_mask_test;
  typedef struct packed {
    logic [19:0] a;
    logic [17:0] d0;
    logic [1:0] s0;
    logic [17:0] d1;
    logic [1:0] s1;
    logic [17:0] e0;
    logic [17:0] e1;
  } ddrbw_row_t;
  localparam ddrbw_row_t ROWS [6] = '{
    '{20'h00010, 18'h2aaaa, 2'h0, 18'h15555, 2'h0, 18'h2aaaa, 18'h15555},
    '{20'h00010, 18'h3ffff, 2'h2, 18'h3ffff, 2'h1, 18'h2abff, 18'h3ff55},
    '{20'h00010, 18'h00000, 2'h3, 18'h00000, 2'h3, 18'h2abff, 18'h3ff55},
    '{20'h00010, 18'h0f0f0, 2'h1, 18'h30303, 2'h0, 18'h0f1ff, 18'h30303},
    '{20'hfffff, 18'h12345, 2'h0, 18'h2fedc, 2'h0, 18'h12345, 18'h2fedc},
    '{20'hfffff, 18'h00000, 2'h1, 18'h3ffff, 2'h2, 18'h00145, 18'h2ffff}
  };
  logic core_clk;
  logic sys_rst;
  logic peekReq;
  logic [19:0] peekAddr;
  logic inClkPos, inClkNeg, loadCmdN, readNotWrite;
  logic [19:0] addrIn;
  logic [17:0] dataIn, dataOut, peekData, got;
  logic [1:0] byteWriteSelectN;
  logic dataOutEn, peekReady, peekValid, bufferReady, commitBusy;
  logic writeDropped;
  int errors;
  int totalChecks;

  ddrbw_ctrl_model u_ddrbw_ctrl_model (
    .core_clk(core_clk), .inClkPos(inClkPos), .inClkNeg(inClkNeg),
    .loadCmdN(loadCmdN), .readNotWrite(readNotWrite), .addrIn(addrIn),
    .dataIn(dataIn), .byteWriteSelectN(byteWriteSelectN));

  ddrbw_top #(.DATA_W(18), .ADDR_W(20), .FIFO_DEPTH(16)) u_ddrbw_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .inClkPos(inClkPos),
    .inClkNeg(inClkNeg), .loadCmdN(loadCmdN),
    .readNotWrite(readNotWrite), .addrIn(addrIn), .dataIn(dataIn),
    .byteWriteSelectN(byteWriteSelectN), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .peekReq(peekReq), .peekReady(peekReady),
    .peekAddr(peekAddr), .peekValid(peekValid), .peekData(peekData),
    .bufferReady(bufferReady), .commitBusy(commitBusy),
    .writeDropped(writeDropped));

  // ****************
  // helpers
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [17:0] g, input logic [17:0] e);
    totalChecks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // holds the request until an edge takes it, then waits for the answer
  task automatic peek(input logic [19:0] a, output logic [17:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    peekReq <= 1'b1;
    peekAddr <= a;
    @(negedge core_clk);
    while (peekReady !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    peekReq <= 1'b0;
    n = 0;
    @(negedge core_clk);
    while (peekValid !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    d = (n < 20) ? peekData : 18'hx;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************
  // tests
  // ****************
  initial begin
    sys_rst = 1'b1;
    peekReq = 1'b0;
    peekAddr = 20'h00000;
    errors = 0;
    totalChecks = 0;
    repeat (7) @(posedge core_clk);
    @(negedge core_clk);
    check(dataOut, 18'h00000);
    check({15'h0000, dataOutEn, bufferReady, peekReady}, 18'h00003);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    $display("reset test done");
    foreach (ROWS[i]) begin
      u_ddrbw_ctrl_model.burst(1'b0, ROWS[i].a, ROWS[i].d0, ROWS[i].s0,
        ROWS[i].d1, ROWS[i].s1);
      peek(ROWS[i].a, got);
      check(got, ROWS[i].e0);
      peek(ROWS[i].a + 20'h00001, got);
      check(got, ROWS[i].e1);
    end
    $display("row tests done");
    u_ddrbw_ctrl_model.burst(1'b1, 20'h00010, 18'h00000, 2'h0,
      18'h00000, 2'h0);
    peek(20'h00010, got);
    check(got, 18'h0f1ff);
    $display("read load test done");
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
endmodule
